// ==== design/ebarb_ctl_if.sv ====
// signals between the arbiter core and its two helpers
// assumes the helpers run on the same clock as the core
`timescale 1ns/100ps
interface ebarb_ctl_if;
	logic cycle_end;
	logic cpu_lock;
	logic cpu_sleep;
	logic cpu_release;
	logic wbe;
	logic wr_start;
	logic wr_done;
	logic int_req;
	logic int_go;
	logic wr_busy;

	modport core (
		output cycle_end, cpu_lock, cpu_sleep, wbe, wr_start, wr_done, int_req,
		input cpu_release, int_go, wr_busy
	);
	modport relpt (
		input cycle_end, cpu_lock, cpu_sleep,
		output cpu_release
	);
	modport wbuf (
		input wbe, wr_start, wr_done, int_req,
		output int_go, wr_busy
	);
endinterface : ebarb_ctl_if

// ==== design/ebarb_pkg.sv ====
// constants and types shared by the external bus arbitration block
// assumes one 100 MHz clock and an asynchronous active-low reset
package ebarb_pkg;

	// ==========================================================
	// pin widths
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int AREA_N = 4;
	localparam int DACK_N = 4;
	localparam int BYTE_N = 2;

	// ==========================================================
	// reset and idle values of the pin drivers
	localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic STROBE_IDLE = 1'b1;
	localparam logic STROBE_HELD = 1'b0;
	localparam logic DATA_FLOAT = 1'b0;

	// ==========================================================
	// master ownership states
	typedef enum logic [2:0] {
		OWN_CPU = 3'b001,
		OWN_CPU_YIELD = 3'b010,
		OWN_DMA = 3'b100
	} ebarb_own_e;

	localparam ebarb_own_e OWN_RST = OWN_CPU;

	// ==========================================================
	// strobe group of one bus cycle, active low
	typedef struct packed {
		logic [AREA_N-1:0] area_select_n;
		logic [BYTE_N-1:0] cas_n;
		logic as_n;
		logic rd_n;
		logic [BYTE_N-1:0] wr_n;
		logic ras_n;
		logic we_n;
		logic [DACK_N-1:0] dack_n;
	} ebarb_strb_s;

	localparam ebarb_strb_s STRB_IDLE = '{
		area_select_n: 4'hf,
		cas_n: 2'h3,
		as_n: 1'b1,
		rd_n: 1'b1,
		wr_n: 2'h3,
		ras_n: 1'b1,
		we_n: 1'b1,
		dack_n: 4'hf
	};

endpackage : ebarb_pkg

// ==== design/ebarb_relpt.sv ====
// finds the points at which the cpu may give up the bus
// assumes lock covers split accesses and read-modify-write series
`timescale 1ns/100ps
module ebarb_relpt
	import ebarb_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	ebarb_ctl_if.relpt ctl
);
	logic series_r;
	logic series_nxt;

	// ==========================================================
	// series tracking
	always_comb begin
		series_nxt = series_r;
		if (ctl.cpu_lock) begin
			series_nxt = 1'b1;
		end else if (ctl.cycle_end) begin
			series_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			series_r <= 1'b0;
		end else begin
			series_r <= series_nxt;
		end
	end

	// ==========================================================
	// release point
	always_comb begin
		if (ctl.cpu_sleep) begin
			ctl.cpu_release = 1'b1;
		end else begin
			ctl.cpu_release = ctl.cycle_end & ~ctl.cpu_lock;
		end
	end
endmodule : ebarb_relpt

// ==== design/ebarb_top.sv ====
// external bus arbitration: master ownership, write buffer gate, idle pins
// assumes masters and the bus cycle engine are synchronous to CLK_I
`timescale 1ns/100ps
module ebarb_top
	import ebarb_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic CPU_REQ_I,
	input wire logic CPU_LOCK_I,
	input wire logic CPU_SLEEP_I,
	input wire logic CYCLE_END_I,
	input wire logic DMA_REQ_I,
	output logic CPU_ACK_O,
	output logic DMA_ACK_O,
	input wire logic WRITE_BUFFER_ENABLE_I,
	input wire logic EXT_WR_START_I,
	input wire logic EXT_WR_DONE_I,
	input wire logic INT_REQ_I,
	output logic INT_GO_O,
	output logic WR_BUSY_O,
	input wire logic CYCLE_ACTIVE_I,
	input wire logic RAS_DOWN_MODE_I,
	input wire logic [ebarb_pkg::AREA_N-1:0] DRAM_AREA_I,
	input wire logic [ebarb_pkg::ADDR_W-1:0] CYC_ADDR_I,
	input wire logic [ebarb_pkg::DATA_W-1:0] CYC_DATA_I,
	input wire logic CYC_DATA_OE_I,
	input wire ebarb_pkg::ebarb_strb_s CYC_STRB_I,
	output logic [ebarb_pkg::ADDR_W-1:0] ADDR_O,
	output logic [ebarb_pkg::DATA_W-1:0] DATA_O,
	output logic DATA_OE_O,
	output logic [ebarb_pkg::AREA_N-1:0] AREA_SELECT_N_O,
	output logic [ebarb_pkg::BYTE_N-1:0] CAS_N_O,
	output logic AS_N_O,
	output logic RD_N_O,
	output logic [ebarb_pkg::BYTE_N-1:0] WR_N_O,
	output logic RAS_N_O,
	output logic WE_N_O,
	output logic [ebarb_pkg::DACK_N-1:0] DACK_N_O
);
	import ebarb_pkg::*;

	// ==========================================================
	// functions
	// hand over at release point
	function automatic logic handover(input logic req, input logic rel);
		return req & rel;
	endfunction : handover

	// one acknowledge per owner, {cpu, dma}
	function automatic logic [1:0] own_acks(input ebarb_own_e st);
		logic [1:0] acks;
		acks = 2'h2;
		case (st)
			OWN_CPU: begin
				acks = 2'h2;
			end
			OWN_CPU_YIELD: begin
				acks = 2'h2;
			end
			OWN_DMA: begin
				acks = 2'h1;
			end
			default: begin
				acks = 2'h2;
			end
		endcase
		return acks;
	endfunction : own_acks

	function automatic ebarb_strb_s idle_strb(input logic held, input logic [AREA_N-1:0] area);
		ebarb_strb_s strb;
		strb = STRB_IDLE;
		if (held) begin
			strb.area_select_n = ~area;
			strb.ras_n = STROBE_HELD;
		end
		return strb;
	endfunction : idle_strb

	// ==========================================================
	// helpers
	ebarb_ctl_if ctl ();
	// bus control bits and cycle events pass straight to the helpers

	assign ctl.cycle_end = CYCLE_END_I;
	assign ctl.cpu_lock = CPU_LOCK_I;
	assign ctl.cpu_sleep = CPU_SLEEP_I;
	assign ctl.wbe = WRITE_BUFFER_ENABLE_I;
	assign ctl.wr_start = EXT_WR_START_I;
	assign ctl.wr_done = EXT_WR_DONE_I;
	assign ctl.int_req = INT_REQ_I;

	ebarb_relpt u_relpt (
		.clk_i(CLK_I),
		.resetn_i(RESETN_I),
		.ctl(ctl.relpt)
	);

	ebarb_wbuf u_wbuf (
		.clk_i(CLK_I),
		.resetn_i(RESETN_I),
		.ctl(ctl.wbuf)
	);

	// ==========================================================
	// ownership state
	ebarb_own_e own_r;
	ebarb_own_e own_nxt;
	logic cpu_ack_r;
	logic cpu_ack_nxt;
	logic dma_ack_r;
	logic dma_ack_nxt;

	always_comb begin
		own_nxt = own_r;
		case (own_r)
			OWN_CPU: begin
				if (handover(DMA_REQ_I, ctl.cpu_release)) begin
					own_nxt = OWN_DMA;
				end else if (DMA_REQ_I) begin
					// a request outside a release point waits in OWN_CPU_YIELD
					own_nxt = OWN_CPU_YIELD;
				end
			end
			OWN_CPU_YIELD: begin
				// series kept whole
				// cpu keeps its ack while it waits, so no cycle is cut
				if (!DMA_REQ_I) begin
					own_nxt = OWN_CPU;
				end else if (handover(DMA_REQ_I, ctl.cpu_release)) begin
					own_nxt = OWN_DMA;
				end
			end
			OWN_DMA: begin
				if (!DMA_REQ_I) begin
					own_nxt = OWN_CPU;
				end
			end
			default: begin
				own_nxt = OWN_RST;
			end
		endcase
	end

	// acknowledge held by owner
	// both acks come from the next state, so they never overlap
	always_comb begin
		{cpu_ack_nxt, dma_ack_nxt} = own_acks(own_nxt);
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			own_r <= OWN_RST;
			cpu_ack_r <= 1'b1;
			dma_ack_r <= 1'b0;
		end else begin
			own_r <= own_nxt;
			cpu_ack_r <= cpu_ack_nxt;
			dma_ack_r <= dma_ack_nxt;
		end
	end

	assign CPU_ACK_O = cpu_ack_r;
	assign DMA_ACK_O = dma_ack_r;

	// ==========================================================
	// write buffer outputs
	logic int_go_r;
	logic int_go_nxt;
	logic wr_busy_r;
	logic wr_busy_nxt;

	// internal access permission, one cycle late
	always_comb begin
		int_go_nxt = ctl.int_go;
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			int_go_r <= 1'b0;
		end else begin
			int_go_r <= int_go_nxt;
		end
	end

	// write in progress flag
	always_comb begin
		wr_busy_nxt = ctl.wr_busy;
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			wr_busy_r <= 1'b0;
		end else begin
			wr_busy_r <= wr_busy_nxt;
		end
	end

	assign INT_GO_O = int_go_r;
	assign WR_BUSY_O = wr_busy_r;

	// ==========================================================
	// pin drivers
	logic [ADDR_W-1:0] addr_r;
	logic [ADDR_W-1:0] addr_nxt;
	logic [DATA_W-1:0] data_r;
	logic [DATA_W-1:0] data_nxt;
	logic data_oe_r;
	logic data_oe_nxt;
	ebarb_strb_s strb_r;
	ebarb_strb_s strb_nxt;
	logic ras_held;

	assign ras_held = RAS_DOWN_MODE_I & (|DRAM_AREA_I);

	// address and data group
	always_comb begin
		addr_nxt = CYC_ADDR_I;
		data_nxt = CYC_DATA_I;
		data_oe_nxt = CYC_DATA_OE_I;
		if (!CYCLE_ACTIVE_I) begin
			// idle address, data floats
			// the next cycle's address is shown early so the bus settles
			data_nxt = DATA_RST;
			data_oe_nxt = DATA_FLOAT;
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			addr_r <= ADDR_RST;
			data_r <= DATA_RST;
			data_oe_r <= DATA_FLOAT;
		end else begin
			addr_r <= addr_nxt;
			data_r <= data_nxt;
			data_oe_r <= data_oe_nxt;
		end
	end

	// strobe group
	always_comb begin
		strb_nxt = CYC_STRB_I;
		if (!CYCLE_ACTIVE_I) begin
			strb_nxt = idle_strb(ras_held, DRAM_AREA_I);
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			strb_r <= STRB_IDLE;
		end else begin
			strb_r <= strb_nxt;
		end
	end

	assign ADDR_O = addr_r;
	assign DATA_O = data_r;
	assign DATA_OE_O = data_oe_r;
	assign AREA_SELECT_N_O = strb_r.area_select_n;
	assign CAS_N_O = strb_r.cas_n;
	assign AS_N_O = strb_r.as_n;
	assign RD_N_O = strb_r.rd_n;
	assign WR_N_O = strb_r.wr_n;
	assign RAS_N_O = strb_r.ras_n;
	assign WE_N_O = strb_r.we_n;
	assign DACK_N_O = strb_r.dack_n;

endmodule : ebarb_top

// ==== design/ebarb_wbuf.sv ====
// tracks external writes and decides when an internal access may run
// assumes start and done are one-cycle pulses from the bus cycle engine
`timescale 1ns/100ps
module ebarb_wbuf
	import ebarb_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	ebarb_ctl_if.wbuf ctl
);
	logic busy_r;
	logic busy_nxt;
	logic first_r;
	logic first_nxt;

	// ==========================================================
	// write state tracking
	always_comb begin
		busy_nxt = busy_r;
		first_nxt = 1'b0;
		if (ctl.wr_start) begin
			busy_nxt = 1'b1;
			first_nxt = 1'b1;
		end else if (ctl.wr_done) begin
			busy_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_r <= 1'b0;
			first_r <= 1'b0;
		end else begin
			busy_r <= busy_nxt;
			first_r <= first_nxt;
		end
	end

	assign ctl.wr_busy = busy_r;

	// ==========================================================
	// internal access permission
	always_comb begin
		if (!ctl.wbe) begin
			ctl.int_go = ctl.int_req & ~busy_r;
		end else begin
			ctl.int_go = ctl.int_req & ~(busy_r & first_r);
		end
	end
endmodule : ebarb_wbuf

// ==== testbench/ebarb_dma_mdl.sv ====
// dma controller model on the far side of the arbiter
// assumes ack and cycle end come from the arbiter clock domain
`timescale 1ns/100ps
module ebarb_dma_mdl (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic act_i,
	input wire logic [3:0] xfers_i,
	input wire logic ack_i,
	input wire logic done_i,
	output logic req_o
);
	logic [3:0] left_r;
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			req_o <= 1'b0;
			left_r <= 4'h0;
		end else if (act_i && !req_o) begin
			req_o <= 1'b1;
			left_r <= xfers_i;
		end else if (req_o && ack_i && done_i) begin
			left_r <= left_r - 4'h1;
			req_o <= (left_r != 4'h1);
		end
	end
endmodule : ebarb_dma_mdl

// ==== testbench/ebarb_top_chk.sv ====
// port checker for the external bus arbitration top
// assumes one clock domain, bound onto ebarb_top
`timescale 1ns/100ps
module ebarb_top_chk (
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic CPU_LOCK_I,
	input wire logic CPU_SLEEP_I,
	input wire logic CYCLE_END_I,
	input wire logic DMA_REQ_I,
	input wire logic CPU_ACK_O,
	input wire logic DMA_ACK_O,
	input wire logic WRITE_BUFFER_ENABLE_I,
	input wire logic EXT_WR_START_I,
	input wire logic EXT_WR_DONE_I,
	input wire logic INT_REQ_I,
	input wire logic INT_GO_O,
	input wire logic WR_BUSY_O,
	input wire logic CYCLE_ACTIVE_I,
	input wire logic RAS_DOWN_MODE_I,
	input wire logic [3:0] DRAM_AREA_I,
	input wire logic [19:0] CYC_ADDR_I,
	input wire logic [19:0] ADDR_O,
	input wire logic DATA_OE_O,
	input wire logic [3:0] AREA_SELECT_N_O,
	input wire logic AS_N_O,
	input wire logic RAS_N_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	// ==========================================
	// sequences
	sequence s_rel;
		CPU_SLEEP_I || (CYCLE_END_I && !CPU_LOCK_I);
	endsequence
	sequence s_wstart;
		EXT_WR_START_I && WRITE_BUFFER_ENABLE_I && INT_REQ_I;
	endsequence
	sequence s_keep;
		INT_REQ_I && WRITE_BUFFER_ENABLE_I && !EXT_WR_START_I && !EXT_WR_DONE_I;
	endsequence
	// ==========================================
	// assertions
	one_owner_a: assert property (!(CPU_ACK_O && DMA_ACK_O))
		else $error("two owners");
	dma_grant_a: assert property (CPU_ACK_O && DMA_REQ_I ##0 s_rel |=> DMA_ACK_O && !CPU_ACK_O)
		else $error("grant missed");
	cpu_hold_a: assert property (CPU_ACK_O && !CPU_SLEEP_I && !CYCLE_END_I |=> CPU_ACK_O)
		else $error("early handover");
	lock_hold_a: assert property (CPU_ACK_O && CPU_LOCK_I && !CPU_SLEEP_I |=> CPU_ACK_O)
		else $error("locked handover");
	dma_keep_a: assert property (DMA_ACK_O && DMA_REQ_I |=> DMA_ACK_O)
		else $error("dma lost bus");
	cpu_default_a: assert property (!DMA_REQ_I |=> CPU_ACK_O)
		else $error("cpu not default");
	idle_pins_a: assert property (!CYCLE_ACTIVE_I |=> ADDR_O == $past(CYC_ADDR_I) && !DATA_OE_O
		&& AS_N_O && (RAS_N_O || $past(RAS_DOWN_MODE_I)))
		else $error("idle pins");
	ras_held_a: assert property (!CYCLE_ACTIVE_I && RAS_DOWN_MODE_I && DRAM_AREA_I != 4'h0
		|=> !RAS_N_O && AREA_SELECT_N_O == ~$past(DRAM_AREA_I))
		else $error("row strobe");
	wb_wait_a: assert property (WR_BUSY_O && $past(WR_BUSY_O) && !$past(WRITE_BUFFER_ENABLE_I)
		&& !$past(WRITE_BUFFER_ENABLE_I, 2) |-> !INT_GO_O)
		else $error("internal ran");
	wb_overlap_a: assert property (s_wstart ##1 s_keep ##1 s_keep |-> !INT_GO_O ##1 INT_GO_O)
		else $error("overlap");
endmodule : ebarb_top_chk

bind ebarb_top ebarb_top_chk ebarb_top_chk_i (.*);

// ==== testbench/ebarb_top_tb.sv ====
// self-checking bench for the external bus arbitration block
// assumes the bound checker and the dma model beside the design
`timescale 1ns/100ps
module ebarb_top_tb;
	import ebarb_pkg::*;
	typedef struct {
		logic act;
		logic ras;
		logic [3:0] area;
		logic [19:0] addr;
		logic [3:0] e_area;
		logic e_ras;
	} ebarb_row_s;
	ebarb_row_s rows [4] = '{
		'{1'b0, 1'b0, 4'h2, 20'h12345, 4'hf, 1'b1},
		'{1'b0, 1'b1, 4'h4, 20'hfffff, 4'hb, 1'b0},
		'{1'b0, 1'b1, 4'h0, 20'h00001, 4'hf, 1'b1},
		'{1'b1, 1'b1, 4'h1, 20'habcde, 4'h0, 1'b0}
	};
	logic clk = 1'b0, resetn = 1'b0, lock = 1'b0, sleep = 1'b0, cend = 1'b0, dreq;
	logic wbe = 1'b1, wst = 1'b0, wdn = 1'b0, ireq = 1'b0, d_act = 1'b0, cact = 1'b1;
	logic ras = 1'b0, go, busy, cack, dack, oe, as_n, ras_n;
	logic [3:0] area = 4'h0, xf = 4'h1, area_n;
	logic [19:0] addr = 20'h0, addr_o;
	logic [15:0] data_o;
	logic [1:0] cas_n, wr_n;
	logic rd_n, we_n;
	logic [3:0] dack_n;
	int n_fail = 0, checked = 0, cyc = 0;

	ebarb_top ebarb_top_i (.CLK_I(clk), .RESETN_I(resetn), .CPU_REQ_I(1'b1),
		.CPU_LOCK_I(lock), .CPU_SLEEP_I(sleep), .CYCLE_END_I(cend), .DMA_REQ_I(dreq),
		.CPU_ACK_O(cack), .DMA_ACK_O(dack), .WRITE_BUFFER_ENABLE_I(wbe),
		.EXT_WR_START_I(wst), .EXT_WR_DONE_I(wdn), .INT_REQ_I(ireq), .INT_GO_O(go),
		.WR_BUSY_O(busy), .CYCLE_ACTIVE_I(cact), .RAS_DOWN_MODE_I(ras), .DRAM_AREA_I(area),
		.CYC_ADDR_I(addr), .CYC_DATA_I(16'h5a5a), .CYC_DATA_OE_I(1'b1), .CYC_STRB_I('0),
		.ADDR_O(addr_o), .DATA_O(data_o), .DATA_OE_O(oe), .AREA_SELECT_N_O(area_n),
		.CAS_N_O(cas_n), .AS_N_O(as_n), .RD_N_O(rd_n), .WR_N_O(wr_n), .RAS_N_O(ras_n),
		.WE_N_O(we_n), .DACK_N_O(dack_n));
	ebarb_dma_mdl ebarb_dma_mdl_i (.clk_i(clk), .resetn_i(resetn), .act_i(d_act),
		.xfers_i(xf), .ack_i(dack), .done_i(cend), .req_o(dreq));

	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			results();
		end
	end

	task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask : step

	initial begin
		step(1);
		chk("cpu_ack", 1, cack);
		step(2);
		resetn = 1'b1;
		foreach (rows[i]) begin
			cact = rows[i].act;
			ras = rows[i].ras;
			area = rows[i].area;
			addr = rows[i].addr;
			step(1);
			chk("addr", rows[i].addr, addr_o);
			chk("pins", {rows[i].e_area, rows[i].e_ras, rows[i].act}, {area_n, ras_n, oe});
			chk("data", rows[i].act ? 20'h05a5a : 20'h00000, data_o);
			chk("strobes", rows[i].act ? 20'h00000 : 20'h007ff,
				{cas_n, as_n, rd_n, wr_n, we_n, dack_n});
		end
		$display("test idle pins done");
		cact = 1'b1;
		xf = 4'h2;
		d_act = 1'b1;
		lock = 1'b1;
		cend = 1'b1;
		step(1);
		d_act = 1'b0;
		step(3);
		chk("dma_ack", 0, dack);
		lock = 1'b0;
		step(1);
		cend = 1'b0;
		chk("dma_ack", 1, dack);
		chk("cpu_ack", 0, cack);
		step(2);
		chk("dma_ack", 1, dack);
		cend = 1'b1;
		step(2);
		cend = 1'b0;
		step(1);
		chk("cpu_ack", 1, cack);
		$display("test arbitration done");
		xf = 4'h1;
		d_act = 1'b1;
		sleep = 1'b1;
		step(1);
		d_act = 1'b0;
		step(1);
		chk("dma_ack", 1, dack);
		resetn = 1'b0;
		#1;
		chk("dma_ack", 0, dack);
		chk("addr", 0, addr_o);
		chk("pins", {4'hf, 1'b1, 1'b0}, {area_n, ras_n, oe});
		step(3);
		resetn = 1'b1;
		sleep = 1'b0;
		chk("cpu_ack", 1, cack);
		$display("test sleep and reset done");
		ireq = 1'b1;
		wst = 1'b1;
		step(1);
		wst = 1'b0;
		step(1);
		chk("int_go", 0, go);
		chk("wr_busy", 1, busy);
		step(1);
		chk("int_go", 1, go);
		wdn = 1'b1;
		step(1);
		wdn = 1'b0;
		wbe = 1'b0;
		step(2);
		chk("wr_busy", 0, busy);
		wst = 1'b1;
		step(1);
		wst = 1'b0;
		step(3);
		chk("int_go", 0, go);
		chk("wr_busy", 1, busy);
		wdn = 1'b1;
		step(1);
		wdn = 1'b0;
		step(2);
		chk("int_go", 1, go);
		$display("test write buffer done");
		results();
	end
endmodule : ebarb_top_tb
